//--- dv/ulpi_link_model.sv
`timescale 1ns/1ps
`default_nettype none
// link controller at the far side of the interface
module ulpi_link_model (
  input wire logic clk_en_in,
  input wire logic dir_in,
  input wire logic nxt_in,
  input wire logic [7:0] bus_in,
  output logic ulpi_clk_out,
  output logic stop_out,
  output logic [7:0] data_out
);
  logic [7:0] link_q;
  logic dir_prev_q;
  logic [7:0] want;
  int tk;
  int st_tk;
  logic [7:0] rxq[$];
  //////////////////////////////////////////////////////////////////////////
  // clock stands still until the device enables its clock output
  initial begin
    ulpi_clk_out = 1'b0;
    link_q = 8'h00;
    stop_out = 1'b0;
    dir_prev_q = 1'b0;
    tk = 0;
    st_tk = 1;
    want = 8'h00;
    #1;
    forever begin
      #80;
      if (clk_en_in === 1'b1) ulpi_clk_out = ~ulpi_clk_out;
    end
  end
  // released lines show the inverse, so a stale copy never passes
  assign data_out = dir_in ? ~link_q : link_q;
  // count interface clocks and sample device bytes
  always @(posedge ulpi_clk_out) begin
    tk = tk + 1;
    if (dir_in === 1'b1 && dir_prev_q === 1'b1) begin
      if (nxt_in === 1'b1) rxq.push_back(bus_in);
      else if (st_tk == 0 && bus_in === want) st_tk = tk;
    end
    dir_prev_q = dir_in;
  end
  // link changes its lines mid-period, well clear of the sampling edge
  task automatic drive(input logic [7:0] b, input logic s);
    @(negedge ulpi_clk_out);
    link_q = b;
    stop_out = s;
  endtask
endmodule
`default_nettype wire

//--- dv/ulpi_phy_core_test.sv
`timescale 1ns/1ps
`default_nettype none
module ulpi_phy_core_test;
  logic ref_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic cs_n = 1'b1, pll = 1'b0, srst = 1'b0, rx_act = 1'b0;
  logic [1:0] spd = 2'h0, ls = 2'h1;
  logic rx_v = 1'b0, flt = 1'b0, fpol = 1'b0, vbus = 1'b0;
  logic [7:0] rx_d = 8'h00;
  logic [7:0] dout, ldata, bus, tx_d;
  logic doe, dir, dir_oe, nxt, nxt_oe, ck_en, rb_clr, rx_rdy;
  logic sync_st, tx_v, eop, bus_power_switch_enable, uclk, stp;
  int failures = 0;
  int n_compared = 0;
  int t0;
  logic [7:0] txq[$];
  assign bus = doe ? dout : ldata;
  always #2.5 ref_clk_in = ~ref_clk_in;
  ulpi_phy_core i_dut (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
    .clk_en_in(1'b1), .ulpi_clk_in(uclk), .chip_select_n_in(cs_n),
    .pll_locked_in(pll), .stop_in(stp), .data_in(bus), .data_out(dout),
    .data_oe_out(doe), .dir_out(dir), .dir_oe_out(dir_oe), .nxt_out(nxt),
    .nxt_oe_out(nxt_oe), .clk_out_en_out(ck_en), .soft_reset_in(srst),
    .reset_bit_clear_out(rb_clr), .speed_in(spd), .line_state_in(ls),
    .rx_active_in(rx_act), .rx_valid_in(rx_v), .rx_data_in(rx_d),
    .rx_ready_out(rx_rdy), .tx_sync_start_out(sync_st), .tx_valid_out(tx_v),
    .tx_data_out(tx_d), .tx_eop_done_out(eop), .fault_in(flt),
    .fault_polarity_in(fpol), .vbus_drive_in(vbus),
    .bus_power_switch_enable_out(bus_power_switch_enable));
  ulpi_link_model i_link (.clk_en_in(ck_en), .dir_in(dir), .nxt_in(nxt),
    .bus_in(bus), .ulpi_clk_out(uclk), .stop_out(stp), .data_out(ldata));
  // bytes handed over on the transmit side
  always @(negedge ref_clk_in) if (tx_v === 1'b1) txq.push_back(tx_d);
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t mismatch seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // start timing a status byte of the given value
  task automatic arm(input logic [7:0] v);
    t0 = i_link.tk;
    i_link.want = v;
    i_link.st_tk = 0;
  endtask
  // a missing byte leaves st_tk at zero and fails the range
  task automatic settle(input int lo, input int hi);
    int d;
    for (int i = 0; i < 400 && i_link.st_tk == 0; i++) @(posedge uclk);
    // the link samples a byte one clock after the device launches it
    d = i_link.st_tk - t0 - 2;
    check(32'(d >= lo && d <= hi), 32'h1);
  endtask
  task automatic ls_to(input logic [1:0] v);
    repeat (3) @(posedge uclk);
    @(negedge uclk);
    @(negedge ref_clk_in);
    ls = v;
    arm({4'h0, 2'h0, v});
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_startup();
    repeat (10) @(negedge ref_clk_in);
    check({dir_oe, nxt_oe, doe}, 32'h0);
    cs_n = 1'b0;
    for (int i = 0; i < 50 && dir_oe !== 1'b1; i++) @(negedge ref_clk_in);
    check({dir, dir_oe, nxt_oe}, 32'h6);
    for (int i = 0; i < 50 && nxt_oe !== 1'b1; i++) @(negedge ref_clk_in);
    check({dir, nxt, dout}, 32'h200);
    repeat (40) @(negedge ref_clk_in);
    check({dir, ck_en}, 32'h2);
    pll = 1'b1;
    for (int i = 0; i < 50 && ck_en !== 1'b1; i++) @(negedge ref_clk_in);
    repeat (2) @(negedge ref_clk_in);
    check(dir, 32'h0);
  endtask
  task automatic t_reset();
    repeat (6) @(posedge uclk);
    @(negedge ref_clk_in);
    check(dir, 32'h0);
    srst = 1'b1;
    for (int i = 0; i < 400 && dir !== 1'b1; i++) @(negedge ref_clk_in);
    check(dir, 32'h1);
    for (int i = 0; i < 900 && rb_clr !== 1'b1; i++) @(negedge ref_clk_in);
    srst = 1'b0;
    check({rb_clr, dir}, 32'h2);
    arm(8'h01);
    settle(1, 8);
  endtask
  task automatic t_power();
    for (int k = 0; k < 8; k++) begin
      @(negedge ref_clk_in);
      {vbus, fpol, flt} = 3'(k);
      repeat (6) @(negedge ref_clk_in);
      check(bus_power_switch_enable, 32'(vbus & (flt ^ fpol)));
    end
  endtask
  task automatic t_line();
    int lo[3] = '{4, 4, 16};
    int hi[3] = '{4, 6, 18};
    for (int k = 0; k < 3; k++) begin
      spd = 2'(k);
      ls_to(2'h2);
      settle(4, 4);
      ls_to(2'h0);
      settle(lo[k], hi[k]);
      ls_to(2'h1);
      settle(4, 4);
    end
  endtask
  // a negative end bound leaves the end of packet unjudged
  task automatic t_tx(input logic [1:0] s, input logic [3:0] pid,
      input int slo, input int shi, input int elo, input int ehi);
    int d;
    spd = s;
    repeat (100) @(negedge ref_clk_in);
    i_link.drive({4'h4, pid}, 1'b0);
    t0 = i_link.tk;
    for (int i = 0; i < 4000 && sync_st !== 1'b1; i++) @(negedge ref_clk_in);
    d = i_link.tk - t0 - 1;
    check(32'(d >= slo && d <= shi), 32'h1);
    txq.delete();
    i_link.drive(8'ha5, 1'b0);
    i_link.drive(8'h3c, 1'b0);
    i_link.drive(8'h00, 1'b1);
    t0 = i_link.tk;
    i_link.drive(8'h00, 1'b0);
    for (int i = 0; i < 900 && eop !== 1'b1; i++) @(negedge ref_clk_in);
    d = i_link.tk - t0 - 1;
    if (elo >= 0) check(32'(d >= elo && d <= ehi), 32'h1);
    check({txq[txq.size()-2], txq[txq.size()-1]}, 32'ha53c);
    // full and low speed: the link reads packet end from status bytes
    if (elo < 0) begin
      ls_to(2'h0);
      settle(s == 2'h1 ? 4 : 16, s == 2'h1 ? 6 : 18);
      ls_to(2'h1);
      settle(4, 4);
    end
  endtask
  task automatic t_rx();
    int n;
    spd = 2'h0;
    repeat (3) @(posedge uclk);
    @(negedge ref_clk_in);
    rx_act = 1'b1;
    arm(8'h11);
    settle(3, 8);
    i_link.rxq.delete();
    n = 0;
    @(negedge ref_clk_in);
    for (int i = 0; i < 200 && rx_rdy === 1'b1; i++) begin
      rx_v = 1'b1;
      rx_d = 8'(n);
      n++;
      @(negedge ref_clk_in);
    end
    rx_v = 1'b0;
    check(32'(n >= 32), 32'h1);
    for (int i = 0; i < 99 && i_link.rxq.size() < n; i++) @(posedge uclk);
    check(i_link.rxq.size(), 32'(n));
    foreach (i_link.rxq[j]) check(i_link.rxq[j], 32'(j[7:0]));
    @(negedge uclk);
    @(negedge ref_clk_in);
    rx_act = 1'b0;
    arm(8'h01);
    settle(3, 8);
  endtask
  task automatic t_off();
    @(negedge ref_clk_in);
    cs_n = 1'b1;
    repeat (20) @(negedge ref_clk_in);
    check({dir_oe, nxt_oe, doe}, 32'h0);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(negedge ref_clk_in);
    arst_n_in = 1'b1;
    t_startup();
    t_reset();
    t_power();
    t_line();
    t_tx(2'h0, 4'h1, 1, 2, 2, 5);
    t_tx(2'h0, 4'h5, 1, 2, 6, 9);
    t_tx(2'h1, 4'h1, 6, 10, -1, -1);
    t_tx(2'h2, 4'h1, 74, 75, -1, -1);
    t_rx();
    t_off();
    report_and_stop();
  end
  // a hang counts as a mismatch
  initial begin
    #400000;
    failures++;
    report_and_stop();
  end
endmodule
`default_nettype wire

//--- logic/ulpi_phy_core.sv
// Contract
// - after power-on reset hold direction high until the PLL is stable
// - with direction high drive next low and status bytes on the data lines
// - reset bit set: direction high until reset ends, then drop and clear bit
// - after every reset send one status byte with current line status; the code arms it after the soft reset only, not after power-on reset
// - device-select deasserted: powered down, every interface pin undriven
// - when power-on reset ends drive direction high first, then other pins low
// - PLL stable: start clock output, drop direction; link then sends reset
// - fault input, polarity selectable, directly controls bus power switch
// - non-SE0 line change: status byte exactly 4 clocks after detection
// - SE0: status byte after 4 HS, 4-6 FS, 16-18 LS clocks
// - transmit command to first sync K: 1-2 HS, 6-10 FS, 74-75 LS
// - HS end of packet done 2-5 clocks after stop is detected
// - HS start-of-frame end of packet takes 6-9 clocks; link waits nine
// - HS receive: direction/next or active status 3-8 clocks after sync K
// - receive end: direction drop or inactive status 3-8, 17-18, 122-123
// - delays count from the interface clock edge that detects the trigger
// - one turnaround clock follows every change of direction
// - direction high: USB data with next high, status with next low
`timescale 1ns/1ps
`default_nettype none
`include "ulpi_phy_params.svh"

module rx_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic clk_en_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_q, wp_d, rp_q, rp_d;
  logic push, pop;

  // one spare pointer bit tells full from empty
  always_comb begin
    in_ready_out = (wp_q - rp_q) != (AW+1)'(DEPTH);
    out_valid_out = wp_q != rp_q;
    push = clk_en_in & in_valid_in & in_ready_out;
    pop = clk_en_in & out_valid_out & out_ready_in;
    wp_d = wp_q + (AW+1)'(push);
    rp_d = rp_q + (AW+1)'(pop);
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end

  // storage is not reset; only entries behind the pointers are read
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wp_q[AW-1:0]] <= in_data_in;
    end
  end
  assign out_data_out = mem[rp_q[AW-1:0]];
endmodule

////////////////////////////////////////////////////////////////////////////
module ulpi_phy_core import ulpi_phy_pkg::*; (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic clk_en_in,
  input wire logic ulpi_clk_in,
  input wire logic chip_select_n_in,
  input wire logic pll_locked_in,
  input wire logic stop_in,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_out,
  output logic dir_out,
  output logic dir_oe_out,
  output logic nxt_out,
  output logic nxt_oe_out,
  output logic clk_out_en_out,
  input wire logic soft_reset_in,
  output logic reset_bit_clear_out,
  input wire logic [1:0] speed_in,
  input wire logic [1:0] line_state_in,
  input wire logic rx_active_in,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_data_in,
  output logic rx_ready_out,
  output logic tx_sync_start_out,
  output logic tx_valid_out,
  output logic [7:0] tx_data_out,
  output logic tx_eop_done_out,
  input wire logic fault_in,
  input wire logic fault_polarity_in,
  input wire logic vbus_drive_in,
  output logic bus_power_switch_enable_out
);
  logic [`SYNC_W-1:0] sy_in, sy_m, sy_s;
  logic uc_p_q, tick, cs_n_s, pll_s, stop_s, fault_s, act_s, srst_s;
  logic [7:0] data_s;
  logic [1:0] ls_s, spd_s;
  state_t st_q, st_d;
  logic [7:0] cnt_q, cnt_d, due_q, due_d, dout_q, dout_d, txd_q, txd_d;
  logic [1:0] ls_q, ls_d;
  logic pend_q, pend_d, act_q, act_d, dir_q, dir_d, dio_q, dio_d;
  logic nxt_q, nxt_d, nxo_q, nxo_d, doe_q, doe_d, clko_q, clko_d;
  logic done_q, done_d, txs_q, txs_d, txe_q, txe_d, txv_q, txv_d;
  logic sof_q, sof_d, acc_q, acc_d, psw_q, psw_d;
  logic fifo_ov, pop;
  logic [7:0] fifo_dat;

  // delay per event kind and speed
  function automatic logic [7:0] dly_f(input ev_t ev, input logic [1:0] spd);
    logic hs, fs;
    hs = spd == `SPD_HS;
    fs = spd == `SPD_FS;
    case (ev)
      ev_se0: dly_f = hs ? `D_SE0_HS : (fs ? `D_SE0_FS : `D_SE0_LS);
      ev_rxs: dly_f = hs ? `D_RXS_HS : `D_JK;
      ev_rxe: dly_f = hs ? `D_RXE_HS : (fs ? `D_RXE_FS : `D_RXE_LS);
      ev_txs: dly_f = hs ? `D_TXS_HS : (fs ? `D_TXS_FS : `D_TXS_LS);
      ev_eop: dly_f = `D_EOP_HS;
      ev_sof: dly_f = `D_EOP_SOF;
      default: dly_f = `D_JK;
    endcase
  endfunction

  // status byte built from the line state at the moment it is sent
  function automatic logic [7:0] rxcmd_f(input logic [1:0] ls, input logic a);
    rxcmd_f = {`ALT_NONE, a ? `RXE_ACTIVE : `RXE_NONE, `VBUS_NONE, ls};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // every pin input passes two flops; the first is read by nothing else
  assign sy_in = {ulpi_clk_in, chip_select_n_in, pll_locked_in, stop_in,
                  data_in, fault_in, line_state_in, rx_active_in,
                  soft_reset_in, speed_in};
  assign {cs_n_s, pll_s, stop_s, data_s, fault_s, ls_s, act_s, srst_s,
          spd_s} = sy_s[`SYNC_W-2:0];
  // one tick per rising interface clock edge
  assign tick = sy_s[`SYNC_W-1] & ~uc_p_q;

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      // a zero here would read as selected and drive pins for two clocks
      sy_m <= `SYNC_RST;
      sy_s <= `SYNC_RST;
      uc_p_q <= 1'b0;
    end else if (clk_en_in) begin
      sy_m <= sy_in;
      sy_s <= sy_m;
      uc_p_q <= sy_s[`SYNC_W-1];
    end
  end

  rx_byte_fifo #(.WIDTH(`FIFO_W), .DEPTH(`FIFO_D)) u_fifo (
    .clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .clk_en_in(clk_en_in),
    .in_valid_in(rx_valid_in),
    .in_ready_out(rx_ready_out),
    .in_data_in(rx_data_in),
    .out_valid_out(fifo_ov),
    .out_ready_in(pop),
    .out_data_out(fifo_dat)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state; start-up steps run on the own clock, the rest per tick
  always_comb begin
    st_d = st_q; cnt_d = cnt_q; due_d = due_q; pend_d = pend_q;
    ls_d = ls_q; act_d = act_q; dir_d = dir_q; dio_d = dio_q;
    nxt_d = nxt_q; nxo_d = nxo_q; doe_d = doe_q; dout_d = dout_q;
    clko_d = clko_q; txd_d = txd_q; sof_d = sof_q; acc_d = acc_q;
    done_d = 1'b0; txs_d = 1'b0; txe_d = 1'b0; txv_d = 1'b0; pop = 1'b0;
    // fault active when it matches the selected polarity
    psw_d = vbus_drive_in & (fault_s != fault_polarity_in);
    if (cs_n_s) begin // powered down, every pin released
      st_d = st_off; dir_d = 1'b0; dio_d = 1'b0; nxt_d = 1'b0;
      nxo_d = 1'b0; doe_d = 1'b0; clko_d = 1'b0; pend_d = 1'b0;
    end else if (st_q == st_off) begin // direction first
      dio_d = 1'b1; dir_d = 1'b1; st_d = st_dir;
    end else if (st_q == st_dir) begin // then the rest low
      nxo_d = 1'b1; nxt_d = 1'b0; doe_d = 1'b1; dout_d = `BYTE_ZERO;
      st_d = st_pll;
    end else if (st_q == st_pll) begin
      if (pll_s) begin // bus released only once the PLL is stable
        clko_d = 1'b1; dir_d = 1'b0; doe_d = 1'b0; st_d = st_td;
        ls_d = ls_s; act_d = act_s;
      end
    end else if (tick) begin
      // status changes arm one timed status byte
      if (pend_q && due_q != `CNT_ZERO) begin
        due_d = due_q - `CNT_ONE;
      end
      if (ls_s != ls_q) begin
        ls_d = ls_s;
        if (!pend_q) begin
          pend_d = 1'b1;
          due_d = dly_f(ls_s == `LS_SE0 ? ev_se0 : ev_jk, spd_s);
        end
      end else if (act_s != act_q) begin
        act_d = act_s;
        if (!pend_q) begin
          pend_d = 1'b1;
          due_d = dly_f(act_s ? ev_rxs : ev_rxe, spd_s);
        end
      end
      case (st_q)
        st_idle: begin
          acc_d = 1'b0;
          if (srst_s) begin // soft reset holds the bus
            dir_d = 1'b1; cnt_d = `RST_TICKS; st_d = st_rst;
          end else if (!stop_s && data_s != `BYTE_ZERO &&
                       data_s[7:6] == `CMD_TX) begin
            st_d = st_tx; nxt_d = 1'b1; cnt_d = dly_f(ev_txs, spd_s);
            sof_d = data_s[3:0] == `PID_SOF;
          end else if (fifo_ov || (pend_q && due_q <= `CNT_TWO)) begin
            dir_d = 1'b1; st_d = st_tu; // data follows one tick later
          end
        end
        st_tu: begin // turnaround passed, start driving
          doe_d = 1'b1; nxt_d = 1'b0; dout_d = rxcmd_f(ls_s, act_s);
          if (pend_q && due_q <= `CNT_ONE) begin
            pend_d = 1'b0;
          end
          st_d = st_rx;
        end
        st_rx: begin
          if (pend_q && due_q <= `CNT_ONE) begin // status, next low
            dout_d = rxcmd_f(ls_s, act_s); nxt_d = 1'b0; pend_d = 1'b0;
          end else if (fifo_ov) begin // USB data, next high
            dout_d = fifo_dat; nxt_d = 1'b1; pop = clk_en_in;
          end else if (!act_s && !pend_q) begin // receive over
            dir_d = 1'b0; doe_d = 1'b0; nxt_d = 1'b0; st_d = st_td;
          end else begin // filler status while waiting
            dout_d = rxcmd_f(ls_s, act_s); nxt_d = 1'b0;
          end
        end
        st_rst: begin // status on the bus while held in reset
          doe_d = 1'b1; nxt_d = 1'b0; dout_d = rxcmd_f(ls_s, act_s);
          cnt_d = cnt_q - `CNT_ONE;
          if (cnt_q == `CNT_ONE) begin // release and clear the bit
            done_d = 1'b1; dir_d = 1'b0; doe_d = 1'b0; st_d = st_td;
            pend_d = 1'b1; due_d = `D_JK; // status after reset
          end
        end
        st_td: st_d = st_idle; // data ignored on turnaround
        st_tx: begin
          if (cnt_q != `CNT_ZERO) begin
            cnt_d = cnt_q - `CNT_ONE;
          end
          txs_d = cnt_q == `CNT_ONE; // first sync K
          acc_d = 1'b1;
          if (stop_s) begin // stop after the last byte
            nxt_d = 1'b0; st_d = st_eop;
            cnt_d = dly_f(sof_q ? ev_sof : ev_eop, spd_s);
          end else if (acc_q) begin
            txv_d = 1'b1; txd_d = data_s;
          end
        end
        st_eop: begin // end of packet counted from the stop tick
          cnt_d = cnt_q - `CNT_ONE;
          if (cnt_q == `CNT_ONE) begin
            txe_d = 1'b1; st_d = st_idle;
          end
        end
        default: st_d = st_off;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q <= st_off; cnt_q <= `CNT_ZERO; due_q <= `CNT_ZERO;
      pend_q <= 1'b0; ls_q <= `LS_SE0; act_q <= 1'b0; dir_q <= 1'b0;
      dio_q <= 1'b0; nxt_q <= 1'b0; nxo_q <= 1'b0; doe_q <= 1'b0;
      dout_q <= `BYTE_ZERO; clko_q <= 1'b0; done_q <= 1'b0; txs_q <= 1'b0;
      txe_q <= 1'b0; txv_q <= 1'b0; txd_q <= `BYTE_ZERO; sof_q <= 1'b0;
      acc_q <= 1'b0; psw_q <= 1'b0;
    end else if (clk_en_in) begin
      st_q <= st_d; cnt_q <= cnt_d; due_q <= due_d; pend_q <= pend_d;
      ls_q <= ls_d; act_q <= act_d; dir_q <= dir_d; dio_q <= dio_d;
      nxt_q <= nxt_d; nxo_q <= nxo_d; doe_q <= doe_d; dout_q <= dout_d;
      clko_q <= clko_d; done_q <= done_d; txs_q <= txs_d; txe_q <= txe_d;
      txv_q <= txv_d; txd_q <= txd_d; sof_q <= sof_d; acc_q <= acc_d;
      psw_q <= psw_d;
    end
  end

  // all pin outputs come straight from flops
  assign data_out = dout_q;
  assign data_oe_out = doe_q;
  assign dir_out = dir_q;
  assign dir_oe_out = dio_q;
  assign nxt_out = nxt_q;
  assign nxt_oe_out = nxo_q;
  assign clk_out_en_out = clko_q;
  assign reset_bit_clear_out = done_q;
  assign tx_sync_start_out = txs_q;
  assign tx_valid_out = txv_q;
  assign tx_data_out = txd_q;
  assign tx_eop_done_out = txe_q;
  assign bus_power_switch_enable_out = psw_q;

  ////////////////////////////////////////////////////////////////////////////
  off_tristate_a: assert property (@(posedge ref_clk_in)
    disable iff (!arst_n_in) (cs_n_s && clk_en_in) |=>
    (!dir_oe_out && !nxt_oe_out && !data_oe_out))
    else $error("pins driven while deselected");
  por_order_a: assert property (@(posedge ref_clk_in)
    disable iff (!arst_n_in) (st_q == st_dir) |->
    (dir_out && dir_oe_out && !nxt_oe_out && !data_oe_out))
    else $error("direction not first after power-on");
  pll_hold_a: assert property (@(posedge ref_clk_in)
    disable iff (!arst_n_in) (st_q == st_pll && !pll_s) |->
    (dir_out && !clk_out_en_out))
    else $error("bus released before pll stable");
  pll_release_a: assert property (@(posedge ref_clk_in)
    disable iff (!arst_n_in) (st_q == st_pll && pll_s && !cs_n_s &&
    clk_en_in) |=> (!dir_out && clk_out_en_out))
    else $error("clock or direction wrong at pll lock");
  rst_hold_a: assert property (@(posedge ref_clk_in)
    disable iff (!arst_n_in) (st_q == st_rst) |-> (dir_out && !nxt_out))
    else $error("reset hold without direction high");
  rst_clear_a: assert property (@(posedge ref_clk_in)
    disable iff (!arst_n_in) reset_bit_clear_out |->
    (!dir_out && $past(st_q) == st_rst))
    else $error("reset bit cleared with bus held");
  rst_status_a: assert property (@(posedge ref_clk_in)
    disable iff (!arst_n_in) reset_bit_clear_out |-> (pend_q && due_q ==
    `D_JK)) else $error("no status byte armed after reset");
  power_switch_a: assert property (@(posedge ref_clk_in)
    disable iff (!arst_n_in) clk_en_in |=> (bus_power_switch_enable_out ==
    $past(vbus_drive_in && (fault_s != fault_polarity_in))))
    else $error("power switch does not follow fault");
  turn_gap_a: assert property (@(posedge ref_clk_in)
    disable iff (!arst_n_in) (st_q == st_tu || st_q == st_td) |->
    !data_oe_out) else $error("data driven in turnaround");
  rxcmd_send_a: assert property (@(posedge ref_clk_in)
    disable iff (!arst_n_in) (tick && clk_en_in && !cs_n_s &&
    (st_q == st_rx || st_q == st_tu) && pend_q && due_q <= `CNT_ONE) |=>
    (data_oe_out && !nxt_out && data_out[1:0] == $past(ls_s)))
    else $error("due status byte not sent");
  tx_start_a: assert property (@(posedge ref_clk_in)
    disable iff (!arst_n_in) tx_sync_start_out |-> ($past(st_q) == st_tx))
    else $error("sync start outside transmit");
endmodule
`default_nettype wire

//--- logic/ulpi_phy_params.svh
`ifndef ULPI_PHY_PARAMS_SVH
`define ULPI_PHY_PARAMS_SVH
// width of the bundle of pin inputs passed through the synchroniser
`define SYNC_W 19
// synchroniser reset value: chip select reads as deselected, pins released
`define SYNC_RST 19'h20000
// speed select encodings
`define SPD_HS 2'h0
`define SPD_FS 2'h1
// line state that marks single-ended zero
`define LS_SE0 2'h0
// transmit command code and start-of-frame packet id
`define CMD_TX 2'h1
`define PID_SOF 4'h5
// status byte fields
`define RXE_ACTIVE 2'h1
`define RXE_NONE 2'h0
`define VBUS_NONE 2'h0
`define ALT_NONE 2'h0
`define BYTE_ZERO 8'h00
// internal soft reset length, in interface clocks
`define RST_TICKS 8'h08
// pipeline delays, in interface clocks from the detecting edge
`define D_JK 8'h04
`define D_SE0_HS 8'h04
`define D_SE0_FS 8'h05
`define D_SE0_LS 8'h11
`define D_RXS_HS 8'h03
`define D_RXE_HS 8'h03
`define D_RXE_FS 8'h11
`define D_RXE_LS 8'h7a
`define D_TXS_HS 8'h01
`define D_TXS_FS 8'h06
`define D_TXS_LS 8'h4a
`define D_EOP_HS 8'h02
`define D_EOP_SOF 8'h06
`define CNT_ONE 8'h01
`define CNT_TWO 8'h02
`define CNT_ZERO 8'h00
// receive buffer shape
`define FIFO_W 8
`define FIFO_D 32
`endif

//--- logic/ulpi_phy_pkg.sv
`default_nettype none
package ulpi_phy_pkg;
  // bus ownership and start-up sequence
  typedef enum logic [3:0] {
    st_off, st_dir, st_pll, st_idle, st_rst,
    st_tu, st_rx, st_td, st_tx, st_eop
  } state_t;
  // kinds of timed pipeline event
  typedef enum logic [2:0] {
    ev_jk, ev_se0, ev_rxs, ev_rxe, ev_txs, ev_eop, ev_sof
  } ev_t;
endpackage
`default_nettype wire
